/* File: rtl/guest_pixel_pkg.sv */
package guest_pixel_pkg;

  // register byte offsets on the apb window
  localparam logic [11:0] LAUNCH_TARGET_OFS  = 12'h124;
  localparam logic [11:0] STROBE_TIMING_OFS  = 12'h12c;
  localparam logic [11:0] GUEST_ACCESS_OFS   = 12'h130;
  localparam logic [11:0] STILL_CONTROL_OFS  = 12'h134;
  localparam logic [11:0] STILL_PIXEL_OFS    = 12'h138;

  // codec launch target fields
  localparam int          TARGET_PORT_LSB    = 4;
  localparam int          TARGET_REG_LSB     = 0;
  localparam logic [2:0]  TARGET_PORT_RESET  = 3'h4;
  localparam logic [2:0]  TARGET_REG_RESET   = 3'h0;

  // timing field: per guest a nibble, duration in the upper pair
  localparam int          TIMING_BITS        = 16;
  localparam logic [15:0] TIMING_RESET       = 16'h0000;
  localparam int          GUEST_FIRST        = 4;

  // guest access control fields
  localparam int          ACCESS_IDX_LSB     = 0;
  localparam int          ACCESS_WRITE_BIT   = 8;
  localparam int          ACCESS_BUSY_BIT    = 31;

  // still control fields and mode codes
  localparam int          MODE_LSB           = 0;
  localparam int          ORDER_BIT          = 2;
  localparam logic [1:0]  MODE_OFF           = 2'h0;
  localparam logic [1:0]  MODE_COMPRESS      = 2'h1;
  localparam logic [1:0]  MODE_DECOMPRESS    = 2'h2;

  // busy flag position per byte order
  localparam int          BUSY_BIT_LITTLE    = 31;
  localparam int          BUSY_BIT_BIG       = 7;

  // strobe timing codes to host clocks
  function automatic logic [3:0] code_to_clocks(input logic [1:0] code);
    unique case (code)
      2'h0:    code_to_clocks = 4'h3;
      2'h1:    code_to_clocks = 4'h4;
      2'h2:    code_to_clocks = 4'hc;
      default: code_to_clocks = 4'hf;
    endcase
  endfunction

endpackage

/* File: rtl/guest_timing_and_still_pixel_regs.sv */
`timescale 1ns/1ps
// What this block does
// - bits 6:4 pick the guest port for the codec launch cycle, reset 100b
// - bits 2:0 pick the codec register for the launch cycle, reset 000b
// - bits 15:14 set guest 7 strobe length: 3, 4, 12, 15 clocks
// - bits 13:12 set guest 7 recovery with the same codes, reset 00
// - guests 6, 5, 4 use nibbles 11:8, 7:4, 3:0 like guest 7
// - busy flag reads at bit 31 little endian, bit 7 big endian
// - compression mode selected: busy reads 0, a pixel may be written
// - compression: host pixel write sets busy at once
// - compression: busy stays until pixel is handed to the video port
// - decompression mode selected: busy reads 1
// - decompression: busy clears once a fetched pixel is ready to read
// - decompression: reading the pixel sets busy until the next fetch
// - busy 1 means register unusable, 0 usable; reset value 0
// - pixel byte order follows the endian select: rgb or bgr word
// - little endian word: red 23:16, green 15:8, blue 7:0
module guest_timing_and_still_pixel_regs
  import guest_pixel_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [2:0]       launch_target_port,
  output logic [2:0]       launch_target_register,
  output logic [2:0]       guest_select,
  output logic             guest_rd_strobe_n,
  output logic             guest_wr_strobe_n,
  output logic [23:0]      video_out_pixel,
  output logic             video_out_valid,
  input  wire logic        video_out_ready,
  input  wire logic [23:0] video_in_pixel,
  input  wire logic        video_in_valid,
  output logic             video_in_ready
);
  import guest_pixel_pkg::*;

  logic [15:0] strobe_timing;
  logic [1:0]  still_mode;
  logic        pixel_byte_order_select;
  logic        setup_phase;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  logic        mapped;
  logic        start_access;
  logic        start_write;
  logic [1:0]  start_idx;
  logic [1:0]  strobe_active_count;
  logic [1:0]  strobe_idle_count;
  logic        engine_busy;
  logic        still_busy;
  logic [23:0] held_pixel;
  logic [23:0] host_pixel;
  logic        pixel_write;
  logic        pixel_read;
  logic [31:0] next_prdata;

  // pixel word packing, rgb for little endian and bgr for big endian
  function automatic logic [23:0] unpack_pixel(input logic [31:0] word, input logic little);
    if (little)
      unpack_pixel = word[23:0];
    else
      unpack_pixel = {word[15:8], word[23:16], word[31:24]};
  endfunction

  function automatic logic [31:0] pack_pixel(input logic [23:0] rgb, input logic little,
                                             input logic flag);
    if (little)
      pack_pixel = {flag, 7'h00, rgb};
    else
      pack_pixel = {rgb[7:0], rgb[15:8], rgb[23:16], flag, 7'h00};
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == LAUNCH_TARGET_OFS) || (addr == STROBE_TIMING_OFS)
             || (addr == GUEST_ACCESS_OFS) || (addr == STILL_CONTROL_OFS)
             || (addr == STILL_PIXEL_OFS);
  endfunction

  // apb handshake: one wait state, answer on the second access cycle
  assign setup_phase = psel && penable && !pready;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite && is_mapped(paddr);
  assign rd_done     = access_done && !pwrite && is_mapped(paddr);
  assign mapped      = is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
    end
  end

  // read data mux, registered on the cycle before pready is seen
  always_comb
  begin
    next_prdata = 32'h00000000;
    unique case (paddr)
      LAUNCH_TARGET_OFS:
        next_prdata = {25'h0000000, launch_target_port, 1'b0, launch_target_register};
      STROBE_TIMING_OFS:
        next_prdata = {16'h0000, strobe_timing};
      GUEST_ACCESS_OFS:
        next_prdata = {engine_busy, 28'h0000000, guest_select};
      STILL_CONTROL_OFS:
        next_prdata = {29'h00000000, pixel_byte_order_select, still_mode};
      STILL_PIXEL_OFS:
        next_prdata = pack_pixel(held_pixel, pixel_byte_order_select, still_busy);
      default:
        next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_phase && !pwrite)
      prdata <= next_prdata;
  end

  // codec launch target; only the two three-bit fields store
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      launch_target_port     <= TARGET_PORT_RESET;
      launch_target_register <= TARGET_REG_RESET;
    end
    else if (wr_done && paddr == LAUNCH_TARGET_OFS)
    begin
      launch_target_port     <= pwdata[TARGET_PORT_LSB +: 3];
      launch_target_register <= pwdata[TARGET_REG_LSB +: 3];
    end
  end

  // guest 4..7 timing nibbles, upper half ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strobe_timing <= TIMING_RESET;
    else if (wr_done && paddr == STROBE_TIMING_OFS)
      strobe_timing <= pwdata[TIMING_BITS-1:0];
  end

  // still mode and byte order control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      still_mode              <= MODE_OFF;
      pixel_byte_order_select <= 1'b1;
    end
    else if (wr_done && paddr == STILL_CONTROL_OFS)
    begin
      still_mode              <= pwdata[MODE_LSB +: 2];
      pixel_byte_order_select <= pwdata[ORDER_BIT];
    end
  end

  // guest access request; a write while the engine runs is dropped
  assign start_access = wr_done && paddr == GUEST_ACCESS_OFS && !engine_busy;
  assign start_write  = pwdata[ACCESS_WRITE_BIT];
  assign start_idx    = pwdata[ACCESS_IDX_LSB +: 2];

  // selected guest's nibble: duration code above recovery code
  assign strobe_active_count = strobe_timing[4*start_idx + 3 -: 2];
  assign strobe_idle_count   = strobe_timing[4*start_idx + 1 -: 2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      guest_select <= 3'h4;
    else if (start_access)
      guest_select <= {1'b1, start_idx};
  end

  strobe_timer u_strobe_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (start_access),
    .start_write (start_write),
    .dur_code    (strobe_active_count),
    .rec_code    (strobe_idle_count),
    .rd_strobe_n (guest_rd_strobe_n),
    .wr_strobe_n (guest_wr_strobe_n),
    .busy        (engine_busy)
  );

  // pixel moves; host is trusted to honour busy, extra moves are ignored
  assign host_pixel  = unpack_pixel(pwdata, pixel_byte_order_select);
  assign pixel_write = wr_done && paddr == STILL_PIXEL_OFS;
  assign pixel_read  = rd_done && paddr == STILL_PIXEL_OFS;

  still_handoff u_still_handoff (
    .pclk            (pclk),
    .presetn         (presetn),
    .mode            (still_mode),
    .host_write      (pixel_write),
    .host_read       (pixel_read),
    .host_pixel      (host_pixel),
    .held_pixel      (held_pixel),
    .busy            (still_busy),
    .video_out_pixel (video_out_pixel),
    .video_out_valid (video_out_valid),
    .video_out_ready (video_out_ready),
    .video_in_pixel  (video_in_pixel),
    .video_in_valid  (video_in_valid),
    .video_in_ready  (video_in_ready)
  );

  chk_target_reset_value: assert property (@(posedge pclk)
    $rose(presetn) |-> launch_target_port == 3'h4 && launch_target_register == 3'h0)
    else $error("launch target reset value wrong");

  chk_target_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && paddr == LAUNCH_TARGET_OFS |=> launch_target_register == $past(pwdata[2:0])
      && launch_target_port == $past(pwdata[6:4]))
    else $error("launch target write lost");

  chk_timing_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == STROBE_TIMING_OFS |-> prdata[31:16] == 16'h0000)
    else $error("timing reserved bits not zero");

  chk_guest7_duration: assert property (@(posedge pclk) disable iff (!presetn)
    start_access && start_idx == 2'h3 && strobe_timing[15:14] == 2'h3
      |=> !(guest_rd_strobe_n && guest_wr_strobe_n) [*8]
      ##1 !(guest_rd_strobe_n && guest_wr_strobe_n) [*7]
      ##1 (guest_rd_strobe_n && guest_wr_strobe_n))
    else $error("guest 7 strobe not fifteen clocks");

  chk_recovery_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(guest_rd_strobe_n & guest_wr_strobe_n)
      |-> (guest_rd_strobe_n & guest_wr_strobe_n) [*3])
    else $error("recovery shorter than three clocks");

  chk_busy_bit_place: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == STILL_PIXEL_OFS
      |-> (pixel_byte_order_select ? prdata[31] : prdata[7]) == $past(still_busy))
    else $error("busy flag at wrong bit");

  chk_compress_write_busy: assert property (@(posedge pclk) disable iff (!presetn)
    pixel_write && still_mode == MODE_COMPRESS && !still_busy
      && $stable(still_mode) |=> still_busy)
    else $error("pixel write did not set busy");

  chk_decompress_enter: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(still_mode) && still_mode == MODE_DECOMPRESS |=> still_busy)
    else $error("decompression entry not busy");

  chk_compress_enter: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(still_mode) && still_mode == MODE_COMPRESS |=> !still_busy)
    else $error("compression entry busy");

  chk_fetch_clears: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(video_in_ready) |-> !still_busy && held_pixel == $past(video_in_pixel))
    else $error("fetched pixel not ready");

  chk_read_sets_busy: assert property (@(posedge pclk) disable iff (!presetn)
    pixel_read && still_mode == MODE_DECOMPRESS && !still_busy
      && $stable(still_mode) |=> still_busy)
    else $error("pixel read did not set busy");

  chk_busy_reset_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> !still_busy)
    else $error("busy not zero after reset");

  chk_little_order: assert property (@(posedge pclk) disable iff (!presetn)
    pixel_write && pixel_byte_order_select && still_mode == MODE_COMPRESS && !still_busy
      && $stable(still_mode) |=> video_out_pixel == $past(pwdata[23:0]))
    else $error("little endian pixel order wrong");

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule

/* File: rtl/still_handoff.sv */
`timescale 1ns/1ps
module still_handoff
  import guest_pixel_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  mode,
  input  wire logic        host_write,
  input  wire logic        host_read,
  input  wire logic [23:0] host_pixel,
  output logic [23:0]      held_pixel,
  output logic             busy,
  output logic [23:0]      video_out_pixel,
  output logic             video_out_valid,
  input  wire logic        video_out_ready,
  input  wire logic [23:0] video_in_pixel,
  input  wire logic        video_in_valid,
  output logic             video_in_ready
);
  logic [1:0] mode_seen;
  logic       fetch;

  assign fetch = (mode == MODE_DECOMPRESS) && busy && video_in_valid && !video_in_ready;

  // busy flag; a mode change restarts the handoff in its idle sense
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_seen <= MODE_OFF;
      busy      <= 1'b0;
    end
    else
    begin
      mode_seen <= mode;
      if (mode != mode_seen)
        busy <= (mode == MODE_DECOMPRESS);
      else if (mode == MODE_COMPRESS && host_write && !busy)
        busy <= 1'b1;
      else if (mode == MODE_COMPRESS && video_out_valid && video_out_ready)
        busy <= 1'b0;
      else if (fetch)
        busy <= 1'b0;
      else if (mode == MODE_DECOMPRESS && host_read && !busy)
        busy <= 1'b1;
    end
  end

  // pixel path toward and from the video port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_pixel      <= 24'h000000;
      video_out_pixel <= 24'h000000;
      video_out_valid <= 1'b0;
      video_in_ready  <= 1'b0;
    end
    else
    begin
      video_in_ready <= fetch;
      if (fetch)
        held_pixel <= video_in_pixel;
      if (mode != MODE_COMPRESS)
        video_out_valid <= 1'b0;
      else if (host_write && !busy && mode == mode_seen)
      begin
        video_out_pixel <= host_pixel;
        video_out_valid <= 1'b1;
      end
      else if (video_out_ready)
        video_out_valid <= 1'b0;
    end
  end

  chk_busy_until_drain: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_COMPRESS && video_out_valid && !video_out_ready && mode == mode_seen)
      |=> busy)
    else $error("busy cleared before pixel left");
endmodule

/* File: rtl/strobe_timer.sv */
`timescale 1ns/1ps
module strobe_timer
  import guest_pixel_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       start_write,
  input  wire logic [1:0] dur_code,
  input  wire logic [1:0] rec_code,
  output logic            rd_strobe_n,
  output logic            wr_strobe_n,
  output logic            busy
);
  typedef enum logic [2:0] {IDLE = 3'b001, ACTIVE = 3'b010, RECOVER = 3'b100} strobe_e;
  strobe_e    state;
  logic [3:0] count;
  logic [1:0] rec_hold;

  // strobe held for duration, then idle for recovery before next start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= IDLE;
      count       <= 4'h0;
      rec_hold    <= 2'h0;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
    end
    else
    begin
      unique case (state)
        IDLE:
        begin
          if (start)
          begin
            state       <= ACTIVE;
            count       <= code_to_clocks(dur_code) - 4'h1;
            rec_hold    <= rec_code;
            rd_strobe_n <= start_write;
            wr_strobe_n <= !start_write;
          end
        end
        ACTIVE:
        begin
          if (count == 4'h0)
          begin
            state       <= RECOVER;
            count       <= code_to_clocks(rec_hold) - 4'h1;
            rd_strobe_n <= 1'b1;
            wr_strobe_n <= 1'b1;
          end
          else
            count <= count - 4'h1;
        end
        RECOVER:
        begin
          if (count == 4'h0)
            state <= IDLE;
          else
            count <= count - 4'h1;
        end
      endcase
    end
  end

  assign busy = (state != IDLE);

  chk_strobe_min_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rd_strobe_n & wr_strobe_n) |-> !(rd_strobe_n & wr_strobe_n) [*3])
    else $error("strobe shorter than three clocks");
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import guest_pixel_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stall;
  logic        guest_rd_strobe_n, guest_wr_strobe_n, last_wr, wb, lit;
  logic        video_out_valid, video_out_ready, video_in_valid, video_in_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, tim, bmask;
  logic [23:0] video_out_pixel, video_in_pixel, offer_pixel, got_pixel, pix;
  logic [2:0]  launch_target_port, launch_target_register, guest_select;
  logic [7:0]  got_count, seen;
  logic [1:0]  dc, rc;
  int          fails, check_count, cycles, run, gap, min_gap, low_len;
  int          clocks [4] = '{3, 4, 12, 15};

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  guest_timing_and_still_pixel_regs i_guest_timing_and_still_pixel_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .launch_target_port(launch_target_port), .launch_target_register(launch_target_register),
    .guest_select(guest_select), .guest_rd_strobe_n(guest_rd_strobe_n),
    .guest_wr_strobe_n(guest_wr_strobe_n), .video_out_pixel(video_out_pixel),
    .video_out_valid(video_out_valid), .video_out_ready(video_out_ready),
    .video_in_pixel(video_in_pixel), .video_in_valid(video_in_valid),
    .video_in_ready(video_in_ready));

  video_side_model i_video_side_model (
    .pclk(pclk), .presetn(presetn), .stall(stall), .offer_pixel(offer_pixel),
    .video_out_pixel(video_out_pixel), .video_out_valid(video_out_valid),
    .video_out_ready(video_out_ready), .video_in_pixel(video_in_pixel),
    .video_in_valid(video_in_valid), .video_in_ready(video_in_ready),
    .got_pixel(got_pixel), .got_count(got_count));

  // strobe low width and high gap, in whole clocks
  always @(posedge pclk)
  begin
    if (!guest_rd_strobe_n || !guest_wr_strobe_n)
    begin
      if (run == 0 && gap < min_gap)
        min_gap = gap;
      if (run == 0)
        last_wr = !guest_wr_strobe_n;
      run = run + 1;
      gap = 0;
    end
    else
    begin
      if (run != 0)
        low_len = run;
      run = 0;
      gap = gap + 1;
    end
  end

  // hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      fails = fails + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("counts: %0d mismatches, %0d comparisons", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    check_count = check_count + 1;
    if (seen_v !== exp_v)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen_v, exp_v);
    end
  endtask

  // one apb transfer; answer taken at the rising edge that sees pready, released there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // pixel word per byte order; busy slot is bit 31 or bit 7
  function automatic logic [31:0] word_of(input logic l, input logic b, input logic [23:0] p);
    return l ? {b, 7'h00, p} : {p[7:0], p[15:8], p[23:16], b, 7'h00};
  endfunction

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn, offer_pixel} = '0;
    stall = 1'b1;
    {fails, check_count, cycles, run, low_len} = '0;
    gap = 1000;
    min_gap = 1000;
    void'($urandom(12));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LAUNCH_TARGET_OFS, 32'h0);
    check(rd, 32'h00000040);
    check({29'h0, launch_target_port}, 32'h4);
    apb(1'b0, STROBE_TIMING_OFS, 32'h0);
    check(rd, 32'h00000000);
    apb(1'b0, STILL_PIXEL_OFS, 32'h0);
    check(rd & 32'h80000000, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // random values, reserved bits must fall away
    repeat (4)
    begin
      r = $urandom();
      apb(1'b1, LAUNCH_TARGET_OFS, r);
      apb(1'b0, LAUNCH_TARGET_OFS, 32'h0);
      check(rd, r & 32'h00000077);
      check({26'h0, launch_target_port, launch_target_register}, {26'h0, r[6:4], r[2:0]});
      apb(1'b1, STROBE_TIMING_OFS, r);
      apb(1'b0, STROBE_TIMING_OFS, 32'h0);
      check(rd, r & 32'h0000ffff);
    end
    // every guest and duration code; accesses hammered so one lands right after busy
    for (int g = 4; g < 8; g++)
      for (int c = 0; c < 4; c++)
      begin
        dc = 2'(c);
        rc = 2'($urandom_range(3));
        wb = 1'($urandom_range(1));
        tim = $urandom() & 32'h0000ffff;
        tim[(g - 4) * 4 +: 4] = {dc, rc};
        apb(1'b1, STROBE_TIMING_OFS, tim);
        min_gap = 1000;
        repeat (14) apb(1'b1, GUEST_ACCESS_OFS, {23'h0, wb, 6'h0, 2'(g - 4)});
        do apb(1'b0, GUEST_ACCESS_OFS, 32'h0); while (rd[31] !== 1'b0);
        check(low_len, clocks[dc]);
        check(min_gap >= clocks[rc], 1);
        check({29'h0, guest_select}, g);
        check(last_wr, wb);
      end
    // both byte orders: compression, then decompression
    for (int o = 0; o < 2; o++)
    begin
      lit = 1'(o);
      bmask = lit ? 32'h80000000 : 32'h00000080;
      apb(1'b1, STILL_CONTROL_OFS, {29'h0, lit, MODE_COMPRESS});
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd & bmask, 32'h0);
      pix = 24'($urandom());
      seen = got_count;
      apb(1'b1, STILL_PIXEL_OFS, word_of(lit, 1'b0, pix));
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd & bmask, bmask);
      stall <= 1'b0;
      while (got_count == seen) @(posedge pclk);
      check({8'h0, got_pixel}, {8'h0, pix});
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd & bmask, 32'h0);
      // far side holds its pixel back until busy has been seen
      stall <= 1'b1;
      offer_pixel <= 24'($urandom());
      apb(1'b1, STILL_CONTROL_OFS, {29'h0, lit, MODE_DECOMPRESS});
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd & bmask, bmask);
      stall <= 1'b0;
      do @(posedge pclk); while (video_in_ready !== 1'b1);
      stall <= 1'b1;
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd, word_of(lit, 1'b0, offer_pixel));
      apb(1'b0, STILL_PIXEL_OFS, 32'h0);
      check(rd & bmask, bmask);
      apb(1'b1, STILL_CONTROL_OFS, {29'h0, lit, MODE_OFF});
    end
    wrap_up();
  end
endmodule

/* File: tb/video_side_model.sv */
`timescale 1ns/1ps
module video_side_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic [23:0] offer_pixel,
  input  wire logic [23:0] video_out_pixel,
  input  wire logic        video_out_valid,
  output logic             video_out_ready,
  output logic [23:0]      video_in_pixel,
  output logic             video_in_valid,
  input  wire logic        video_in_ready,
  output logic [23:0]      got_pixel,
  output logic [7:0]       got_count
);
  logic present;

  // output side takes a pixel only while ready, which follows !stall one clock late
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      video_out_ready <= 1'b0;
      got_pixel       <= 24'h000000;
      got_count       <= 8'h00;
    end
    else
    begin
      video_out_ready <= !stall;
      if (video_out_valid && video_out_ready)
      begin
        got_pixel <= video_out_pixel;
        got_count <= got_count + 8'h01;
      end
    end

  // input side drops its offer for a cycle after each take
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      present <= 1'b0;
    else
      present <= !video_in_ready;

  // an idle line shows the inverse, so stale data never looks valid
  assign video_in_valid = present && !stall;
  assign video_in_pixel = video_in_valid ? offer_pixel : ~offer_pixel;
endmodule
